// *** src/pps_top.sv ***
`timescale 1ns/1ps
`include "pps_params.svh"

module pps_top #(
    parameter int TICK_CYCLES = `PPS_TICK_CYCLES
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic [`PPS_ADDR_W-1:0]  reg_addr,
    input  wire logic [`PPS_REG_W-1:0]   reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [`PPS_REG_W-1:0]   reg_rdata,
    input  wire logic                    panel_on_req,
    input  wire pps_pkg::pps_gfx_t       gfx_mode,
    input  wire logic [`PPS_LINE_W-1:0]  panel_lines,
    input  wire pps_pkg::pps_pix_t       pix_in,
    output pps_pkg::pps_pix_t            pix_out,
    output logic                         panel_logic_power_enable,
    output logic                         panel_clk_data_enable,
    output logic                         panel_bias_power_enable
);

    // ---------------- Register file ----------------
    logic [`PPS_REG_W-1:0] mode_q;
    logic [`PPS_REG_W-1:0] mode_d;
    logic [`PPS_REG_W-1:0] rdata_d;
    logic [`PPS_REG_W-1:0] status;

    logic                  power_up_seq_enable;
    logic                  power_down_seq_enable;
    logic [1:0]            seq_delay_select;
    logic                  center_en;
    logic                  blank_en;
    logic                  reverse_video;

    assign power_up_seq_enable   = mode_q[`PPS_BIT_UP_EN];
    assign power_down_seq_enable = mode_q[`PPS_BIT_DN_EN];
    assign seq_delay_select      = mode_q[`PPS_DLY_HI:`PPS_DLY_LO];
    assign center_en             = mode_q[`PPS_BIT_CENTER];
    assign blank_en              = mode_q[`PPS_BIT_BLANK];
    assign reverse_video         = mode_q[`PPS_BIT_RVV];

    always_comb begin
        mode_d = mode_q;
        if (reg_wr && reg_addr == `PPS_MODE_ADDR) begin
            mode_d = reg_wdata & `PPS_MODE_WMASK;
        end
    end

    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            case (reg_addr)
                `PPS_MODE_ADDR: rdata_d = mode_q;
                `PPS_STAT_ADDR: rdata_d = status;
                default:        rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_q    <= `PPS_MODE_RST;
            reg_rdata <= '0;
        end else begin
            mode_q    <= mode_d;
            reg_rdata <= rdata_d;
        end
    end

    // ---------------- Request synchroniser ----------------
    logic [1:0] req_sync_q;
    logic [1:0] req_sync_d;
    logic       req_on;

    assign req_sync_d = {req_sync_q[0], panel_on_req};
    assign req_on     = req_sync_q[1];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_sync_q <= `PPS_SYNC_RST;
        end else begin
            req_sync_q <= req_sync_d;
        end
    end

    // ---------------- Power sequencer ----------------
    pps_pkg::pps_state_t state_q;
    pps_pkg::pps_state_t state_d;
    logic                logic_q;
    logic                logic_d;
    logic                data_q;
    logic                data_d;
    logic                bias_q;
    logic                bias_d;
    logic                tmr_start;
    logic                tmr_done;

    pps_delay_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (tmr_start),
        .sel     (seq_delay_select),
        .done    (tmr_done)
    );

    always_comb begin
        state_d   = state_q;
        logic_d   = logic_q;
        data_d    = data_q;
        bias_d    = bias_q;
        tmr_start = 1'b0;
        case (state_q)
            pps_pkg::PPS_OFF: begin
                if (req_on) begin
                    if (power_up_seq_enable) begin
                        logic_d   = 1'b1;
                        tmr_start = 1'b1;
                        state_d   = pps_pkg::PPS_UP_LOGIC;
                    end else begin
                        logic_d = 1'b1;
                        data_d  = 1'b1;
                        bias_d  = 1'b1;
                        state_d = pps_pkg::PPS_ON;
                    end
                end
            end
            pps_pkg::PPS_UP_LOGIC: begin
                if (tmr_done) begin
                    data_d    = 1'b1;
                    tmr_start = 1'b1;
                    state_d   = pps_pkg::PPS_UP_DATA;
                end
            end
            pps_pkg::PPS_UP_DATA: begin
                if (tmr_done) begin
                    bias_d  = 1'b1;
                    state_d = pps_pkg::PPS_ON;
                end
            end
            pps_pkg::PPS_ON: begin
                if (!req_on) begin
                    if (power_down_seq_enable) begin
                        bias_d    = 1'b0;
                        tmr_start = 1'b1;
                        state_d   = pps_pkg::PPS_DN_BIAS;
                    end else begin
                        logic_d = 1'b0;
                        data_d  = 1'b0;
                        bias_d  = 1'b0;
                        state_d = pps_pkg::PPS_OFF;
                    end
                end
            end
            pps_pkg::PPS_DN_BIAS: begin
                if (tmr_done) begin
                    data_d    = 1'b0;
                    tmr_start = 1'b1;
                    state_d   = pps_pkg::PPS_DN_DATA;
                end
            end
            pps_pkg::PPS_DN_DATA: begin
                if (tmr_done) begin
                    logic_d = 1'b0;
                    state_d = pps_pkg::PPS_OFF;
                end
            end
            default: begin
                logic_d = 1'b0;
                data_d  = 1'b0;
                bias_d  = 1'b0;
                state_d = pps_pkg::PPS_OFF;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= pps_pkg::PPS_OFF;
            logic_q <= 1'b0;
            data_q  <= 1'b0;
            bias_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            logic_q <= logic_d;
            data_q  <= data_d;
            bias_q  <= bias_d;
        end
    end

    assign panel_logic_power_enable = logic_q;
    assign panel_clk_data_enable    = data_q;
    assign panel_bias_power_enable  = bias_q;

    always_comb begin
        status                  = '0;
        status[`PPS_STAT_LOGIC] = logic_q;
        status[`PPS_STAT_DATA]  = data_q;
        status[`PPS_STAT_BIAS]  = bias_q;
        status[`PPS_STAT_BUSY]  = (state_q != pps_pkg::PPS_OFF) &&
                                  (state_q != pps_pkg::PPS_ON);
    end

    // ---------------- Pixel path ----------------
    logic                   gfx_low;
    logic [`PPS_LINE_W-1:0] src_lines;
    logic                   taller;
    logic [`PPS_LINE_W-1:0] offset;
    logic [`PPS_LINE_W-1:0] rel_line;
    logic                   in_img;
    logic                   blank_now;
    pps_pkg::pps_pix_t      pix_d;
    pps_pkg::pps_pix_t      pix_q;

    always_comb begin
        gfx_low   = (gfx_mode == pps_pkg::PPS_GFX_640X200) ||
                    (gfx_mode == pps_pkg::PPS_GFX_640X400);
        src_lines = (gfx_mode == pps_pkg::PPS_GFX_640X400) ?
                    `PPS_SRC_LINES_HI : `PPS_SRC_LINES_LO;
        taller    = gfx_low && (panel_lines > src_lines);
        offset    = '0;
        if (center_en && taller) begin
            offset = (panel_lines - src_lines) >> 1;
        end
        rel_line  = pix_in.line - offset;
        in_img    = (pix_in.line >= offset) && (rel_line < src_lines);
        blank_now = blank_en && taller && !in_img;
    end

    always_comb begin
        pix_d       = '0;
        pix_d.valid = pix_in.valid && data_q;
        pix_d.line  = in_img ? rel_line : '0;
        if (!data_q || blank_now) begin
            pix_d.data = '0;
        end else if (reverse_video) begin
            pix_d.data = ~pix_in.data;
        end else begin
            pix_d.data = pix_in.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pix_q <= '0;
        end else begin
            pix_q <= pix_d;
        end
    end

    assign pix_out = pix_q;

endmodule : pps_top

// *** src/pps_params.svh ***
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH

// Register map
`define PPS_ADDR_W            8
`define PPS_REG_W             8
`define PPS_MODE_ADDR         8'hCC
`define PPS_STAT_ADDR         8'hCD
`define PPS_MODE_RST          8'h00
`define PPS_MODE_WMASK        8'h7F

// Mode register fields
`define PPS_BIT_UP_EN         6
`define PPS_BIT_DN_EN         5
`define PPS_DLY_HI            4
`define PPS_DLY_LO            3
`define PPS_BIT_CENTER        2
`define PPS_BIT_BLANK         1
`define PPS_BIT_RVV           0

// Status register fields
`define PPS_STAT_LOGIC        0
`define PPS_STAT_DATA         1
`define PPS_STAT_BIAS         2
`define PPS_STAT_BUSY         3

// Timing
`define PPS_CLK_PERIOD_NS     40
`define PPS_TICK_NS           500000
`define PPS_TICK_CYCLES       (`PPS_TICK_NS / `PPS_CLK_PERIOD_NS)
`define PPS_DLY0_US           7500
`define PPS_DLY1_US           15000
`define PPS_DLY2_US           30000
`define PPS_DLY3_US           60000
`define PPS_US_TO_TICKS(us)   (((us) * 1000) / `PPS_TICK_NS)
`define PPS_PRE_W             16
`define PPS_TCNT_W            8

// Video
`define PPS_LINE_W            9
`define PPS_PIX_W             8
`define PPS_SRC_LINES_LO      9'h0C8
`define PPS_SRC_LINES_HI      9'h190
`define PPS_SYNC_RST          2'h0

`endif

// *** src/pps_pkg.sv ***
package pps_pkg;

    typedef enum logic [1:0] {
        PPS_GFX_OTHER,
        PPS_GFX_640X200,
        PPS_GFX_640X400
    } pps_gfx_t;

    typedef enum logic [2:0] {
        PPS_OFF,
        PPS_UP_LOGIC,
        PPS_UP_DATA,
        PPS_ON,
        PPS_DN_BIAS,
        PPS_DN_DATA
    } pps_state_t;

    typedef struct packed {
        logic                  valid;
        logic [8:0]            line;
        logic [7:0]            data;
    } pps_pix_t;

endpackage : pps_pkg

// *** src/pps_delay_timer.sv ***
`timescale 1ns/1ps
`include "pps_params.svh"

module pps_delay_timer #(
    parameter int TICK_CYCLES = `PPS_TICK_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [1:0] sel,
    output logic            done
);

    localparam logic [`PPS_PRE_W-1:0]  PRE_LAST = `PPS_PRE_W'(TICK_CYCLES - 1);
    localparam logic [`PPS_TCNT_W-1:0] T0 = `PPS_TCNT_W'(`PPS_US_TO_TICKS(`PPS_DLY0_US));
    localparam logic [`PPS_TCNT_W-1:0] T1 = `PPS_TCNT_W'(`PPS_US_TO_TICKS(`PPS_DLY1_US));
    localparam logic [`PPS_TCNT_W-1:0] T2 = `PPS_TCNT_W'(`PPS_US_TO_TICKS(`PPS_DLY2_US));
    localparam logic [`PPS_TCNT_W-1:0] T3 = `PPS_TCNT_W'(`PPS_US_TO_TICKS(`PPS_DLY3_US));

    logic [`PPS_PRE_W-1:0]  pre_q;
    logic [`PPS_PRE_W-1:0]  pre_d;
    logic [`PPS_TCNT_W-1:0] left_q;
    logic [`PPS_TCNT_W-1:0] left_d;
    logic                   run_q;
    logic                   run_d;
    logic                   done_d;
    logic [`PPS_TCNT_W-1:0] load;

    always_comb begin
        case (sel)
            2'h0:    load = T0;
            2'h1:    load = T1;
            2'h2:    load = T2;
            default: load = T3;
        endcase
    end

    // Done is not registered, so the next step lands exactly one delay after start
    always_comb begin
        pre_d  = pre_q;
        left_d = left_q;
        run_d  = run_q;
        done_d = run_q && (pre_q == PRE_LAST) && (left_q == `PPS_TCNT_W'(1));
        if (start) begin
            pre_d  = '0;
            left_d = load;
            run_d  = 1'b1;
        end else if (run_q) begin
            if (pre_q == PRE_LAST) begin
                pre_d  = '0;
                left_d = left_q - `PPS_TCNT_W'(1);
                if (left_q == `PPS_TCNT_W'(1)) begin
                    run_d  = 1'b0;
                end
            end else begin
                pre_d = pre_q + `PPS_PRE_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pre_q  <= '0;
            left_q <= '0;
            run_q  <= 1'b0;
        end else begin
            pre_q  <= pre_d;
            left_q <= left_d;
            run_q  <= run_d;
        end
    end

    assign done = done_d;

endmodule : pps_delay_timer

// *** test/pps_top_chk_assertions.sv ***
`timescale 1ns/1ps
`include "pps_params.svh"
module pps_top_chk #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic [`PPS_ADDR_W-1:0] reg_addr,
    input wire logic [`PPS_REG_W-1:0]  reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [`PPS_REG_W-1:0]  reg_rdata,
    input wire logic                   panel_on_req,
    input wire pps_pkg::pps_gfx_t      gfx_mode,
    input wire logic [`PPS_LINE_W-1:0] panel_lines,
    input wire pps_pkg::pps_pix_t      pix_in,
    input wire pps_pkg::pps_pix_t      pix_out,
    input wire logic                   panel_logic_power_enable,
    input wire logic                   panel_clk_data_enable,
    input wire logic                   panel_bias_power_enable
);
    logic [7:0]  mode_q, mode_d;
    logic [2:0]  en_q, en_d, en;
    logic [15:0] cnt_q, cnt_d, dly;
    logic        blank_hit;
    always_comb begin
        en = {panel_bias_power_enable, panel_clk_data_enable, panel_logic_power_enable};
        en_d = en;
        mode_d = (reg_wr && reg_addr == `PPS_MODE_ADDR) ? (reg_wdata & `PPS_MODE_WMASK) : mode_q;
        cnt_d = (en != en_q) ? 16'h0000 : cnt_q + 16'h0001;
        dly = 16'((15 << mode_q[4:3]) * TICK_CYCLES);
        blank_hit = pix_in.valid && gfx_mode == pps_pkg::PPS_GFX_640X200 && mode_q[1]
            && !mode_q[2] && panel_lines > 9'h0C8 && pix_in.line >= 9'h0C8;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_q <= 8'h00;
            en_q   <= 3'h0;
            cnt_q  <= 16'h0000;
        end else begin
            mode_q <= mode_d;
            en_q   <= en_d;
            cnt_q  <= cnt_d;
        end
    end
    chk_up_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(panel_bias_power_enable) |-> panel_clk_data_enable && panel_logic_power_enable)
        else $error("bias power rose before logic power and clocks");
    chk_dn_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(panel_logic_power_enable) |-> !panel_clk_data_enable && !panel_bias_power_enable)
        else $error("logic power fell before bias power and clocks");
    chk_up_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ($rose(panel_clk_data_enable) || $rose(panel_bias_power_enable)) && mode_q[6]
        |-> cnt_q == dly - 16'h0001) else $error("power up step gap wrong");
    chk_dn_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ($fell(panel_clk_data_enable) || $fell(panel_logic_power_enable)) && mode_q[5]
        |-> cnt_q == dly - 16'h0001) else $error("power down step gap wrong");
    chk_up_flat: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(panel_logic_power_enable) && !mode_q[6]
        |-> panel_clk_data_enable && panel_bias_power_enable) else $error("unsequenced up split");
    chk_dn_flat: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(panel_bias_power_enable) && !mode_q[5]
        |-> !panel_clk_data_enable && !panel_logic_power_enable) else $error("unsequenced dn split");
    chk_rvv_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(pix_in.valid) && $past(gfx_mode) == pps_pkg::PPS_GFX_OTHER
        && $past(panel_clk_data_enable) && panel_clk_data_enable
        |-> pix_out.data == ($past(mode_q[0]) ? ~$past(pix_in.data) : $past(pix_in.data)))
        else $error("pixel polarity wrong");
    chk_blank_line: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(blank_hit) |-> pix_out.data == 8'h00) else $error("unused line not blanked");
endmodule : pps_top_chk
bind pps_top pps_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.ref_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .panel_on_req, .gfx_mode, .panel_lines, .pix_in,
    .pix_out, .panel_logic_power_enable, .panel_clk_data_enable, .panel_bias_power_enable);

// *** test/pps_panel_model.sv ***
`timescale 1ns/1ps
module pps_panel_model (
    input wire logic [2:0] power_en,
    input wire logic       ref_clk,
    output int             t_up [3],
    output int             t_dn [3]
);
    int         cyc = 0;
    logic [2:0] en_q = 3'h0;
    // Stamps the cycle each supply or clock switch turns on and off
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        en_q <= power_en;
        for (int i = 0; i < 3; i++) begin
            if (power_en[i] && !en_q[i]) t_up[i] <= cyc;
            if (!power_en[i] && en_q[i]) t_dn[i] <= cyc;
        end
    end
endmodule : pps_panel_model

// *** test/pps_top_tb.sv ***
`timescale 1ns/1ps
`include "pps_params.svh"
module pps_top_tb;
    localparam int TK = 4;
    logic              ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, panel_on_req = 0;
    logic [7:0]        reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [8:0]        panel_lines = 9'h0C8;
    pps_pkg::pps_gfx_t gfx_mode = pps_pkg::PPS_GFX_OTHER;
    pps_pkg::pps_pix_t pix_in = '0, pix_out;
    logic [2:0]        en;
    int                t_up [3], t_dn [3];
    int                failures = 0, cmp_count = 0;
    always #20 ref_clk = ~ref_clk;
    pps_top #(.TICK_CYCLES(TK)) DUT (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .panel_on_req, .gfx_mode, .panel_lines, .pix_in, .pix_out,
        .panel_logic_power_enable(en[0]), .panel_clk_data_enable(en[1]),
        .panel_bias_power_enable(en[2]));
    pps_panel_model u_panel (.power_en(en), .ref_clk, .t_up(t_up), .t_dn(t_dn));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (e !== g) begin
            failures++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(logic [7:0] a, logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
        @(posedge ref_clk);
        #1 chk("reg_rdata idle", 8'h00, reg_rdata);
    endtask : rd_chk
    task automatic power(logic on, logic [2:0] e);
        int n = 0;
        @(posedge ref_clk);
        panel_on_req <= on;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (en !== e && n < 3000);
        chk("enables", e, en);
        // Panel model stamps the last switch one edge later
        @(posedge ref_clk);
        #1;
    endtask : power
    task automatic t_regs();
        rd_chk(`PPS_MODE_ADDR, 8'h00);
        wr(`PPS_MODE_ADDR, 8'hFF);
        rd_chk(`PPS_MODE_ADDR, 8'h7F);
        wr(8'h33, 8'h12);
        rd_chk(8'h33, 8'h00);
        rd_chk(`PPS_MODE_ADDR, 8'h7F);
    endtask : t_regs
    task automatic t_seq(logic [1:0] s);
        int d = (15 << s) * TK;
        wr(`PPS_MODE_ADDR, {3'b011, s, 3'b000});
        power(1'b1, 3'h7);
        chk("up logic to data", d, t_up[1] - t_up[0]);
        chk("up data to bias", d, t_up[2] - t_up[1]);
        rd_chk(`PPS_STAT_ADDR, 8'h07);
        power(1'b0, 3'h0);
        rd_chk(`PPS_STAT_ADDR, 8'h00);
        chk("dn bias to data", d, t_dn[1] - t_dn[2]);
        chk("dn data to logic", d, t_dn[0] - t_dn[1]);
    endtask : t_seq
    task automatic t_flat();
        wr(`PPS_MODE_ADDR, 8'h18);
        power(1'b1, 3'h7);
        chk("flat up", t_up[0], t_up[2]);
        power(1'b0, 3'h0);
        chk("flat dn", t_dn[0], t_dn[1]);
    endtask : t_flat
    task automatic pix(logic [7:0] m, pps_pkg::pps_gfx_t g, logic [8:0] pl, logic [8:0] ln,
                       logic [7:0] dt, logic [8:0] el, logic [7:0] ed, logic ev);
        wr(`PPS_MODE_ADDR, m);
        @(posedge ref_clk);
        gfx_mode <= g; panel_lines <= pl; pix_in <= '{valid: 1'b1, line: ln, data: dt};
        @(posedge ref_clk);
        pix_in.valid <= 1'b0;
        #1 chk("pix valid", ev, pix_out.valid);
        chk("pix data", ed, pix_out.data);
        if (ev) chk("pix line", el, pix_out.line);
    endtask : pix
    task automatic t_pixels();
        power(1'b1, 3'h7);
        pix(8'h00, pps_pkg::PPS_GFX_OTHER, 9'h0C8, 9'h005, 8'h3C, 9'h005, 8'h3C, 1);
        pix(8'h01, pps_pkg::PPS_GFX_OTHER, 9'h0C8, 9'h005, 8'h3C, 9'h005, 8'hC3, 1);
        pix(8'h04, pps_pkg::PPS_GFX_640X200, 9'h0F0, 9'h019, 8'h3C, 9'h005, 8'h3C, 1);
        pix(8'h02, pps_pkg::PPS_GFX_640X200, 9'h0F0, 9'h0D2, 8'h3C, 9'h000, 8'h00, 1);
        pix(8'h06, pps_pkg::PPS_GFX_640X400, 9'h1E0, 9'h01E, 8'h3C, 9'h000, 8'h00, 1);
        pix(8'h05, pps_pkg::PPS_GFX_640X400, 9'h1E0, 9'h02D, 8'h0F, 9'h005, 8'hF0, 1);
        power(1'b0, 3'h0);
        pix(8'h00, pps_pkg::PPS_GFX_OTHER, 9'h0C8, 9'h005, 8'h3C, 9'h005, 8'h00, 0);
    endtask : t_pixels
    task automatic close_out();
        if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        for (int s = 0; s < 4; s++) t_seq(2'(s));
        t_flat();
        t_pixels();
        close_out();
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        failures++;
        close_out();
    end
endmodule : pps_top_tb
